// file: src/uart_intr_modem.sv
// Interrupt identification, enables and modem control/status of one channel
// Behaviour
// RULE_01: Identification frozen during its read
// RULE_02: Bit 0 low when enabled interrupt pending
// RULE_03: Identification bits 3 to 7 read zero
// RULE_04: Priority line, receive, transmit, modem status
// RULE_05: Each source clears by its own access
// RULE_06: Test bit routes baud clock or data
// RULE_07: Enable bits 0-3 gate four sources
// RULE_08: Disabled source neither reported nor requests
// RULE_09: Enable bits 4 to 7 read zero
// RULE_10: Control bit 0 drives terminal-ready inverted
// RULE_11: Control bit 1 drives request-to-send inverted
// RULE_12: Control bit 2 is plain general flag
// RULE_13: Control bit 3 gates interrupt output
// RULE_14: Control bit 4 selects loopback
// RULE_15: Loopback maps control bits to status
// RULE_16: Loopback forces pins high in AT mode
// RULE_17: Loopback change sources from control bits
// RULE_18: Control bits 5 to 7 read zero
// RULE_19: Change bits set on edges, clear on read
// RULE_20: Ring change only on trailing edge
// RULE_21: Any change bit requests modem interrupt
// RULE_22: Status bits 4-7 are inverted inputs
// RULE_23: Change during read survives the clear
// RULE_24: Scratch byte, absent in XT mode
//
// The register offsets and strobed register access are this design's own decisions.
`include "uart_intr_modem_defines.svh"

module uart_intr_modem
	import uart_intr_modem_pkg::*;
(
	input  wire logic       clk,              // 20 MHz clock
	input  wire logic       sys_rst,          // Synchronous reset, high
	input  wire logic [2:0] reg_addr,         // Register offset
	input  wire logic [7:0] reg_wdata,        // Write data
	input  wire logic       reg_wr,           // Write strobe
	input  wire logic       reg_rd,           // Read strobe
	output logic      [7:0] reg_rdata,        // Read data, one cycle later
	input  wire logic       xt_mode,          // High: XT mode, low: AT mode
	input  wire logic       line_err_event,   // Line error detected, pulse
	input  wire logic       rx_ready_event,   // Character received, pulse
	input  wire logic       tx_empty_event,   // Holding reg emptied, pulse
	input  wire logic [7:0] line_status_in,   // Line status from receiver
	input  wire logic       tx_shift_out,     // Transmit shift output
	input  wire logic       baud_clk_n,       // Baud clock output level
	input  wire logic       serial_rx_pin,    // Serial input pin
	input  wire logic       cts_n,            // Clear-to-send pin
	input  wire logic       dsr_n,            // Data-set-ready pin
	input  wire logic       ri_n,             // Ring pin
	input  wire logic       dcd_n,            // Carrier-detect pin
	output logic            serial_tx_pin,    // Routed serial output pin
	output logic            rx_shift_in,      // Receive shift input
	output logic            dtr_n,            // Terminal-ready pin
	output logic            rts_n,            // Request-to-send pin
	output logic            irq_line_a        // Channel interrupt request
);

	logic [3:0] enables;
	logic [4:0] mctrl;
	logic       route_sel;
	logic [7:0] scratch;
	logic       ls_pend, rx_pend, tx_pend;
	logic [3:0] chg;
	logic [3:0] prev_st;
	logic [7:0] id_view;
	id_phase_t  id_phase;
	logic [3:0] next_enables;
	logic [4:0] next_mctrl;
	logic       next_route_sel;
	logic [7:0] next_scratch;
	logic       next_ls_pend, next_rx_pend, next_tx_pend;
	logic [3:0] next_chg;
	logic [3:0] next_prev_st;
	logic [7:0] next_id_view;
	id_phase_t  next_id_phase;
	logic [7:0] next_rdata;
	logic       next_tx_pin, next_rx_in, next_dtr_n, next_rts_n, next_irq;

	logic       loop;
	logic [3:0] cur_st;   // cts, dsr, ri, dcd in true sense
	logic [7:0] mstat;
	logic [7:0] live_id;
	logic       any_pend;
	logic       rd_id, rd_ls, rd_ms, rd_rx, wr_tx;
	logic [3:0] edge_seen;

	// Ring reports only its trailing edge, the others any change
	for (genvar i = 0; i < `MS_LINES; i++) begin : g_edge
		if (i == `MS_RING) begin : g_ring
			assign edge_seen[i] = prev_st[i] & ~cur_st[i]; // [RULE_20]
		end else begin : g_delta
			assign edge_seen[i] = prev_st[i] ^ cur_st[i]; // [RULE_19]
		end
	end

	always_comb begin
		loop = mctrl[`MC_LOOP];
		rd_id = reg_rd && reg_addr == `OFS_IDENTITY;
		rd_ls = reg_rd && reg_addr == `OFS_LSTAT;
		rd_ms = reg_rd && reg_addr == `OFS_MSTAT;
		rd_rx = reg_rd && reg_addr == `OFS_DATA;
		wr_tx = reg_wr && reg_addr == `OFS_DATA;
		if (loop) begin
			// Control bits stand in for the modem inputs [RULE_15] [RULE_17]
			cur_st = {mctrl[`MC_IGATE], mctrl[`MC_FLAG],
				mctrl[`MC_TERM], mctrl[`MC_RTS]};
			cur_st = {cur_st[3], cur_st[2], cur_st[1], cur_st[0]};
		end else begin
			cur_st = {~dcd_n, ~ri_n, ~dsr_n, ~cts_n}; // [RULE_14] [RULE_22]
		end
		mstat = {cur_st, chg}; // [RULE_22]
		// Priority encode enabled sources only [RULE_04] [RULE_07] [RULE_08]
		any_pend = 1'b1;
		if (ls_pend && enables[`IE_LS])
			live_id = {`ZERO5, SRC_LINE, 1'b0};
		else if (rx_pend && enables[`IE_RX])
			live_id = {`ZERO5, SRC_RX, 1'b0};
		else if (tx_pend && enables[`IE_TX])
			live_id = {`ZERO5, SRC_TX, 1'b0};
		else if ((|chg) && enables[`IE_MS]) // [RULE_21]
			live_id = {`ZERO5, SRC_MODEM, 1'b0};
		else begin
			live_id = `ID_NONE; // [RULE_02] [RULE_03]
			any_pend = 1'b0;
		end
	end

	// Register writes and read data
	always_comb begin
		next_enables = enables;
		next_mctrl = mctrl;
		next_route_sel = route_sel;
		next_scratch = scratch;
		next_rdata = `RST_BYTE;
		if (reg_wr) begin
			case (reg_addr)
				`OFS_ENABLES: next_enables = reg_wdata[3:0]; // [RULE_07]
				`OFS_MCTRL:   next_mctrl = reg_wdata[4:0];
				`OFS_TEST:    next_route_sel = reg_wdata[`TC_ROUTE]; // [RULE_06]
				`OFS_SCRATCH: if (!xt_mode) next_scratch = reg_wdata; // [RULE_24]
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				`OFS_IDENTITY: next_rdata = id_view; // [RULE_01]
				`OFS_ENABLES:  next_rdata = {`ZERO4, enables}; // [RULE_09]
				`OFS_MCTRL:    next_rdata = {`ZERO3, mctrl}; // [RULE_18] [RULE_12]
				`OFS_LSTAT:    next_rdata = line_status_in;
				`OFS_MSTAT:    next_rdata = mstat;
				`OFS_SCRATCH:  next_rdata = xt_mode ? `RST_BYTE : scratch;
				default:       next_rdata = `RST_BYTE;
			endcase
		end
	end

	// Pending sources; a new event wins over its clear [RULE_05]
	always_comb begin
		next_ls_pend = (ls_pend && !rd_ls) || line_err_event;
		next_rx_pend = (rx_pend && !rd_rx) || rx_ready_event;
		next_tx_pend = tx_pend;
		if (wr_tx || (rd_id && id_view[2:1] == SRC_TX && !id_view[0]))
			next_tx_pend = 1'b0;
		if (tx_empty_event)
			next_tx_pend = 1'b1;
		next_prev_st = cur_st;
		next_chg = rd_ms ? `RST_NIB : chg; // [RULE_19]
		// Edges set after the clear so none is lost [RULE_23]
		next_chg = next_chg | edge_seen; // [RULE_19] [RULE_20]
	end

	// Freeze the indication while identification is being read [RULE_01]
	always_comb begin
		next_id_phase = rd_id ? ID_READING : ID_IDLE;
		case (id_phase)
			ID_IDLE:    next_id_view = rd_id ? id_view : live_id;
			ID_READING: next_id_view = rd_id ? id_view : live_id;
			default:    next_id_view = live_id;
		endcase
	end

	// Pin outputs
	always_comb begin
		next_rx_in = loop ? tx_shift_out : serial_rx_pin; // [RULE_14]
		next_tx_pin = route_sel ? baud_clk_n
			: (loop ? 1'b1 : tx_shift_out); // [RULE_06] [RULE_14]
		if (loop && !xt_mode) begin
			next_dtr_n = 1'b1; // [RULE_16]
			next_rts_n = 1'b1;
		end else begin
			next_dtr_n = ~mctrl[`MC_TERM]; // [RULE_10]
			next_rts_n = ~mctrl[`MC_RTS]; // [RULE_11]
		end
		next_irq = any_pend && mctrl[`MC_IGATE]; // [RULE_13] [RULE_08]
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			enables <= `RST_NIB;
			mctrl <= `RST_BITS5;
			route_sel <= 1'b0;
			scratch <= `RST_BYTE;
			ls_pend <= 1'b0;
			rx_pend <= 1'b0;
			tx_pend <= 1'b0;
			chg <= `RST_NIB;
			prev_st <= `RST_NIB;
			id_view <= `ID_NONE;
			id_phase <= ID_IDLE;
			reg_rdata <= `RST_BYTE;
			serial_tx_pin <= 1'b1;
			rx_shift_in <= 1'b1;
			dtr_n <= 1'b1;
			rts_n <= 1'b1;
			irq_line_a <= 1'b0;
		end else begin
			enables <= next_enables;
			mctrl <= next_mctrl;
			route_sel <= next_route_sel;
			scratch <= next_scratch;
			ls_pend <= next_ls_pend;
			rx_pend <= next_rx_pend;
			tx_pend <= next_tx_pend;
			chg <= next_chg;
			prev_st <= next_prev_st;
			id_view <= next_id_view;
			id_phase <= next_id_phase;
			reg_rdata <= next_rdata;
			serial_tx_pin <= next_tx_pin;
			rx_shift_in <= next_rx_in;
			dtr_n <= next_dtr_n;
			rts_n <= next_rts_n;
			irq_line_a <= next_irq;
		end
	end

endmodule : uart_intr_modem

// file: src/uart_intr_modem_defines.svh
// Register offsets, field positions and reset values of the channel block
`ifndef UART_INTR_MODEM_DEFINES_SVH
`define UART_INTR_MODEM_DEFINES_SVH

`define OFS_IDENTITY   3'h2
`define OFS_ENABLES    3'h1
`define OFS_TEST       3'h7
`define OFS_MCTRL      3'h4
`define OFS_LSTAT      3'h5
`define OFS_MSTAT      3'h6
`define OFS_SCRATCH    3'h3
`define OFS_DATA       3'h0

`define IE_RX          0
`define IE_TX          1
`define IE_LS          2
`define IE_MS          3
`define MC_TERM        0
`define MC_RTS         1
`define MC_FLAG        2
`define MC_IGATE       3
`define MC_LOOP        4
`define TC_ROUTE       4
`define MS_RING        2
`define MS_LINES       4

`define ID_NONE        8'h01
`define RST_BYTE       8'h00
`define RST_NIB        4'h0
`define RST_BITS5      5'h00
`define ZERO3          3'h0
`define ZERO4          4'h0
`define ZERO5          5'h00

`endif

// file: src/uart_intr_modem_pkg.sv
// Types shared by the interrupt and modem-control channel block
package uart_intr_modem_pkg;
	typedef enum logic [1:0] {
		SRC_MODEM,
		SRC_TX,
		SRC_RX,
		SRC_LINE
	} intr_source_t;

	typedef enum logic {
		ID_IDLE,
		ID_READING
	} id_phase_t;
endpackage : uart_intr_modem_pkg

// file: tb/uart_intr_modem_monitor.sv
// Port checker of the channel block
module uart_intr_modem_monitor (
	input wire logic       clk,           // Clock
	input wire logic       sys_rst,       // Reset
	input wire logic [2:0] reg_addr,      // Offset
	input wire logic [7:0] reg_wdata,     // Write data
	input wire logic       reg_wr,        // Write
	input wire logic       reg_rd,        // Read
	input wire logic [7:0] reg_rdata,     // Read data
	input wire logic       xt_mode,       // Mode
	input wire logic       cts_n,         // Modem in
	input wire logic       dsr_n,         // Modem in
	input wire logic       ri_n,          // Modem in
	input wire logic       dcd_n,         // Modem in
	input wire logic       serial_tx_pin, // Serial out
	input wire logic       dtr_n,         // Modem out
	input wire logic       rts_n,         // Modem out
	input wire logic       irq_line_a     // Interrupt
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	chk_dtr_drive: assert property (
		reg_wr && reg_addr == 3'h4 && !reg_wdata[4]
		|-> ##2 dtr_n == !$past(reg_wdata[0], 2)) else $error("dtr level");
	chk_rts_drive: assert property (
		reg_wr && reg_addr == 3'h4 && !reg_wdata[4]
		|-> ##2 rts_n == !$past(reg_wdata[1], 2)) else $error("rts level");
	chk_id_upper: assert property (
		reg_rd && reg_addr == 3'h2 |=> reg_rdata[7:3] == 5'h00)
		else $error("identity upper bits set");
	chk_ie_upper: assert property (
		reg_rd && reg_addr == 3'h1 |=> reg_rdata[7:4] == 4'h0)
		else $error("enable upper bits set");
	chk_mc_upper: assert property (
		reg_rd && reg_addr == 3'h4 |=> reg_rdata[7:5] == 3'h0)
		else $error("control upper bits set");
	chk_scratch_xt: assert property (
		reg_rd && reg_addr == 3'h3 && xt_mode |=> reg_rdata == 8'h00)
		else $error("scratch visible in xt mode");
	chk_change_clear: assert property (
		!$past(reg_wr) && reg_rd && reg_addr == 3'h6
		&& $stable({cts_n, dsr_n, ri_n, dcd_n})
		##1 reg_rd && reg_addr == 3'h6 && $stable({cts_n, dsr_n, ri_n, dcd_n})
		|=> reg_rdata[3:0] == 4'h0) else $error("change bits not cleared");
	chk_reset_idle: assert property ($fell(sys_rst)
		|-> dtr_n && rts_n && serial_tx_pin && !irq_line_a)
		else $error("outputs not idle after reset");
	cover property (reg_rd && reg_addr == 3'h2 ##1 reg_rdata == 8'h06);
	cover property (irq_line_a);
	cover property (xt_mode && !dtr_n);
endmodule : uart_intr_modem_monitor

bind uart_intr_modem uart_intr_modem_monitor mon_u (.clk, .sys_rst,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .xt_mode, .cts_n,
	.dsr_n, .ri_n, .dcd_n, .serial_tx_pin, .dtr_n, .rts_n, .irq_line_a);

// file: tb/uart_intr_modem_test.sv
// Self-checking bench of the channel block
module uart_intr_modem_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, xt_mode = 0;
	logic        line_err_event = 0, rx_ready_event = 0, tx_empty_event = 0;
	logic        tx_shift_out = 1, baud_clk_n = 1, serial_rx_pin = 1;
	logic [2:0]  reg_addr = 3'h0;
	logic [7:0]  reg_wdata = 8'h00, reg_rdata, line_status_in = 8'h1e;
	logic [3:0]  want = 4'hf;
	logic        cts_n, dsr_n, ri_n, dcd_n, serial_tx_pin, rx_shift_in;
	logic        dtr_n, rts_n, irq_line_a;
	int          n_mismatch = 0, comparisons = 0;
	logic [18:0] rows [4] = '{{3'h1, 8'hff, 8'h0f}, {3'h4, 8'hef, 8'h0f},
		{3'h3, 8'ha5, 8'ha5}, {3'h7, 8'h00, 8'h00}};
	uart_intr_modem dut_u (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .xt_mode, .line_err_event, .rx_ready_event,
		.tx_empty_event, .line_status_in, .tx_shift_out, .baud_clk_n,
		.serial_rx_pin, .cts_n, .dsr_n, .ri_n, .dcd_n, .serial_tx_pin,
		.rx_shift_in, .dtr_n, .rts_n, .irq_line_a);
	uart_modem_partner modem_u (.clk, .want, .cts_n, .dsr_n, .ri_n, .dcd_n);
	always #25 clk = ~clk;
	task automatic check(logic [7:0] seen, logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: %h vs %h", $time, seen, exp);
		end
	endtask : check
	task automatic pin(logic s, logic e);
		check({7'h00, s}, {7'h00, e});
	endtask : pin
	task automatic wr(logic [2:0] a, logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 0;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask : wr
	task automatic rd(logic [2:0] a, logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 0;
		@(negedge clk);
		if (!$isunknown(e)) check(reg_rdata, e);
	endtask : rd
	// Two reads back to back, each answer taken while it stands
	task automatic rd2(logic [2:0] a, logic [7:0] e1, logic [7:0] e2);
		@(posedge clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clk);
		@(negedge clk);
		check(reg_rdata, e1);
		@(posedge clk);
		reg_rd <= 0;
		@(negedge clk);
		check(reg_rdata, e2);
	endtask : rd2
	task automatic fire(logic [2:0] v);
		@(posedge clk);
		{line_err_event, rx_ready_event, tx_empty_event} <= v;
		@(posedge clk);
		{line_err_event, rx_ready_event, tx_empty_event} <= 3'h0;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask : fire
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	initial begin
		repeat (3000) @(posedge clk);
		n_mismatch++;
		summarize;
	end
	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 0;
		rd(3'h2, 8'h01);
		foreach (rows[i]) begin
			wr(rows[i][18:16], rows[i][15:8]);
			rd(rows[i][18:16], rows[i][7:0]);
		end
		pin(dtr_n, 0);
		pin(rts_n, 0);
		fire(3'h7);
		rd(3'h2, 8'h06);
		pin(irq_line_a, 1);
		rd(3'h5, 8'h1e);
		rd(3'h2, 8'h04);
		rd(3'h0, 8'hxx);
		rd(3'h2, 8'h02);
		rd(3'h2, 8'h01);
		wr(3'h1, 8'h00);
		fire(3'h2);
		rd(3'h2, 8'h01);
		pin(irq_line_a, 0);
		wr(3'h1, 8'h01);
		rd(3'h2, 8'h04);
		rd(3'h0, 8'hxx);
		wr(3'h1, 8'h08);
		@(posedge clk);
		want <= 4'he;
		repeat (4) @(posedge clk);
		@(negedge clk);
		pin(irq_line_a, 1);
		rd(3'h6, 8'h11);
		rd(3'h6, 8'h10);
		@(posedge clk);
		want <= 4'ha;
		repeat (4) @(posedge clk);
		rd(3'h6, 8'h50);
		@(posedge clk);
		want <= 4'he;
		repeat (4) @(posedge clk);
		rd2(3'h6, 8'h14, 8'h10);
		@(posedge clk);
		tx_shift_out <= 0;
		wr(3'h4, 8'h1f);
		rd(3'h6, 8'hfa);
		pin(dtr_n, 1);
		pin(serial_tx_pin, 1);
		pin(rx_shift_in, 0);
		@(posedge clk);
		xt_mode <= 1;
		rd(3'h3, 8'h00);
		pin(rts_n, 0);
		@(posedge clk);
		xt_mode <= 0;
		wr(3'h4, 8'h00);
		rd(3'h6, 8'h1e);
		// Pin edge lands on the edge of the status read
		@(posedge clk);
		want <= 4'hf;
		rd(3'h6, 8'h00);
		rd(3'h6, 8'h01);
		// Reset in mid-run returns the scratch byte to zero
		wr(3'h3, 8'h5a);
		@(posedge clk);
		sys_rst <= 1;
		repeat (2) @(posedge clk);
		sys_rst <= 0;
		rd(3'h3, 8'h00);
		pin(dtr_n, 1);
		wr(3'h7, 8'h10);
		pin(serial_tx_pin, 1);
		wr(3'h7, 8'h00);
		pin(serial_tx_pin, 0);
		summarize;
	end
endmodule : uart_intr_modem_test

// file: tb/uart_modem_partner.sv
// Modem-side model driving the four handshake lines, idle high
module uart_modem_partner (
	input  wire logic       clk,   // Clock
	input  wire logic [3:0] want,  // Levels: dcd, ri, dsr, cts
	output logic            cts_n, // Clear-to-send
	output logic            dsr_n, // Data-set-ready
	output logic            ri_n,  // Ring
	output logic            dcd_n  // Carrier-detect
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] pins = 4'hf;
	always @(posedge clk) begin
		pins <= want;
	end
	assign {dcd_n, ri_n, dsr_n, cts_n} = pins;
endmodule : uart_modem_partner
